// ==== rtl/ssec_top.sv ====
// serial port enable and interrupt control with axi4-lite registers
// Functional notes
// - conflict irq passes only when its mask is 1
// - receive mask gates rx-full and overrun together
// - transmit-end irq passes only when mask is 1
// - transmit-empty irq passes only when mask is 1
// - control bits two and one read zero
// - overrun when byte completes with buffer full and receive enabled
// - four-wire chip select rise sets conflict flag
// - enabled requests merge onto one interrupt output
`timescale 1ns/10ps
module ssec_top
  import ssec_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          serial_clk,
  input  wire logic          serial_din,
  input  wire logic          chip_select_pin,
  output logic               serial_dout,
  output logic               serial_dout_oe,
  output logic               irq
);
  ssec_eng_if eif ();

  logic [7:0]    sec_reg;
  logic [7:0]    status_reg;
  logic [7:0]    status_next;
  logic [7:0]    irq_mask_next;
  logic [7:0]    tx_buf_reg;
  logic          tx_full_reg;
  logic [7:0]    rx_buf_reg;
  logic          rx_full_reg;
  logic [7:0]    mode_reg;
  logic          aw_hold_reg;
  logic          w_hold_reg;
  logic [AW-1:0] awaddr_reg;
  logic [7:0]    wdata_reg;
  logic          wstrb0_reg;
  logic          wr_fire;
  logic          rd_fire;
  logic [9:0]    wr_idx;
  logic [9:0]    rd_idx;
  logic          wr_b0;
  logic [7:0]    rd_val;
  logic          rd_ok;
  logic          ovr_evt;
  logic          rxf_evt;
  logic          ce_evt;

  ssec_engine u_engine (
    .core_clk           (core_clk),
    .nrst               (nrst),
    .eif                (eif),
    .serial_clk         (serial_clk),
    .serial_din         (serial_din),
    .chip_select_pin    (chip_select_pin),
    .serial_dout_reg    (serial_dout),
    .serial_dout_oe_reg (serial_dout_oe)
  );

  assign eif.transmit_enable = sec_reg[B_TX_EN];
  assign eif.receive_enable  = sec_reg[B_RX_EN];
  assign eif.tx_req          = tx_full_reg;
  assign eif.tx_data         = tx_buf_reg;

  // write address and data are caught independently, in either order
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= BYTE_ZERO;
      wstrb0_reg    <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~aw_hold_reg & ~s_axi_bvalid;
      s_axi_wready  <= s_axi_wvalid & ~s_axi_wready & ~w_hold_reg & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  assign wr_fire = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  assign wr_idx  = awaddr_reg[11:2];
  assign wr_b0   = wr_fire & wstrb0_reg;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_idx  = s_axi_araddr[11:2];

  // write response; unmapped index answers slverr
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_idx == IDX_SEC || wr_idx == IDX_STATUS || wr_idx == IDX_TXDATA ||
                       wr_idx == IDX_RXDATA || wr_idx == IDX_MODE) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read data selection
  always_comb begin
    rd_val = BYTE_ZERO;
    rd_ok  = 1'b1;
    unique case (rd_idx)
      IDX_SEC:    rd_val = sec_reg & SEC_WMASK;
      IDX_STATUS: rd_val = status_reg;
      IDX_TXDATA: rd_val = {7'h00, tx_full_reg};
      IDX_RXDATA: rd_val = rx_buf_reg;
      IDX_MODE:   rd_val = mode_reg;
      default:    rd_ok  = 1'b0;
    endcase
  end

  // read channel, one read in flight
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_val};
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // control register; unassigned bits never store
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sec_reg  <= SEC_RESET;
      mode_reg <= BYTE_ZERO;
    end else if (wr_b0 && wr_idx == IDX_SEC) begin
      sec_reg <= wdata_reg & SEC_WMASK;
    end else if (wr_b0 && wr_idx == IDX_MODE) begin
      mode_reg <= wdata_reg & 8'h01;
    end
  end

  // transmit buffer; a write in the take cycle refills it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_full_reg <= 1'b0;
      tx_buf_reg  <= BYTE_ZERO;
    end else if (wr_b0 && wr_idx == IDX_TXDATA) begin
      tx_full_reg <= 1'b1;
      tx_buf_reg  <= wdata_reg;
    end else if (eif.take) begin
      tx_full_reg <= 1'b0;
    end
  end

  // receive side events; full flag still set when its read lands counts as full
  assign rxf_evt = eif.byte_done & eif.receive_enable & ~rx_full_reg;
  assign ovr_evt = eif.byte_done & eif.receive_enable & rx_full_reg;
  assign ce_evt  = eif.cs_rise & mode_reg[M_FOUR_WIRE];

  // receive buffer; the overrun byte is discarded so the first stays readable
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_full_reg <= 1'b0;
      rx_buf_reg  <= BYTE_ZERO;
    end else if (rxf_evt) begin
      rx_full_reg <= 1'b1;
      rx_buf_reg  <= eif.rx_byte;
    end else if (rd_fire && rd_idx == IDX_RXDATA) begin
      rx_full_reg <= 1'b0;
    end
  end

  // sticky status, cleared by its read; a new event wins over the clear
  always_comb begin
    status_next = (rd_fire && rd_idx == IDX_STATUS) ? STAT_RESET : status_reg;
    status_next[S_CONFLICT] = status_next[S_CONFLICT] | ce_evt;
    status_next[S_OVERRUN]  = status_next[S_OVERRUN] | ovr_evt;
    status_next[S_RXFULL]   = status_next[S_RXFULL] | rxf_evt;
    status_next[S_TEND]     = status_next[S_TEND] | eif.tx_end;
    status_next[S_TEMPTY]   = status_next[S_TEMPTY] | eif.take;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status_reg <= STAT_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // mask follows the control bits that the next edge will hold
  always_comb begin
    irq_mask_next = BYTE_ZERO;
    irq_mask_next[S_CONFLICT] = (wr_b0 && wr_idx == IDX_SEC) ? wdata_reg[B_CONFLICT]
                                                              : sec_reg[B_CONFLICT];
    irq_mask_next[S_OVERRUN]  = (wr_b0 && wr_idx == IDX_SEC) ? wdata_reg[B_RX_IRQ]
                                                              : sec_reg[B_RX_IRQ];
    irq_mask_next[S_RXFULL]   = irq_mask_next[S_OVERRUN];
    irq_mask_next[S_TEND]     = (wr_b0 && wr_idx == IDX_SEC) ? wdata_reg[B_TEND_IRQ]
                                                              : sec_reg[B_TEND_IRQ];
    irq_mask_next[S_TEMPTY]   = (wr_b0 && wr_idx == IDX_SEC) ? wdata_reg[B_TEMPTY_IRQ]
                                                              : sec_reg[B_TEMPTY_IRQ];
  end

  // single interrupt line, registered so it lines up with status_reg
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_next & irq_mask_next);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_ce_pass:    assert property (status_reg[S_CONFLICT] && sec_reg[B_CONFLICT] |-> irq)
    else $error("conflict request not forwarded");
  a_ce_block:   assert property (status_reg == 8'h01 && !sec_reg[B_CONFLICT] |-> !irq)
    else $error("conflict request not blocked");
  a_rx_pass:    assert property ((status_reg[S_RXFULL] || status_reg[S_OVERRUN])
                                 && sec_reg[B_RX_IRQ] |-> irq)
    else $error("receive request not forwarded");
  a_rx_block:   assert property ((status_reg & 8'hCF) == 8'h00 && !sec_reg[B_RX_IRQ]
                                 |-> !irq)
    else $error("receive request not blocked");
  a_tend_gate:  assert property ((status_reg & 8'hBF) == 8'h00 |->
                                 irq == (status_reg[S_TEND] && sec_reg[B_TEND_IRQ]))
    else $error("transmit end gating wrong");
  a_tempty_gate: assert property ((status_reg & 8'h7F) == 8'h00 |->
                                  irq == (status_reg[S_TEMPTY] && sec_reg[B_TEMPTY_IRQ]))
    else $error("transmit empty gating wrong");
  a_rsvd_zero:  assert property (sec_reg[2:1] == 2'h0)
    else $error("unassigned control bits set");
  a_tx_start:   assert property ($rose(eif.take) |-> $past(sec_reg[B_TX_EN]))
    else $error("transmit started while disabled");
  a_rx_accept:  assert property ($rose(rx_full_reg) |-> $past(sec_reg[B_RX_EN]))
    else $error("receive accepted while disabled");
  a_overrun_set: assert property (eif.byte_done && rx_full_reg && sec_reg[B_RX_EN]
                                  |=> status_reg[S_OVERRUN] && $stable(rx_buf_reg))
    else $error("overrun not flagged");
  a_conflict_set: assert property (eif.cs_rise && mode_reg[M_FOUR_WIRE]
                                   |=> status_reg[S_CONFLICT])
    else $error("conflict not flagged");
  a_irq_merge:  assert property (irq == |(status_reg & {sec_reg[7:5], sec_reg[5],
                                 3'h0, sec_reg[0]}))
    else $error("interrupt line disagrees with status");

  c_irq_rise:   cover property ($rose(irq));
  c_overrun:    cover property (ovr_evt);
  c_conflict:   cover property (ce_evt);
  c_tx_end:     cover property (eif.tx_end ##[1:200] eif.take);
endmodule

// ==== rtl/ssec_pkg.sv ====
// constants for the serial enable and interrupt control block
package ssec_pkg;
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned AW           = 12;
  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_SEC      = 10'h0BB;
  localparam logic [9:0]  IDX_STATUS   = 10'h0C0;
  localparam logic [9:0]  IDX_TXDATA   = 10'h0C1;
  localparam logic [9:0]  IDX_RXDATA   = 10'h0C2;
  localparam logic [9:0]  IDX_MODE     = 10'h0C3;
  // serial_enable_control fields
  localparam int unsigned B_CONFLICT   = 0;
  localparam int unsigned B_RX_EN      = 3;
  localparam int unsigned B_TX_EN      = 4;
  localparam int unsigned B_RX_IRQ     = 5;
  localparam int unsigned B_TEND_IRQ   = 6;
  localparam int unsigned B_TEMPTY_IRQ = 7;
  localparam logic [7:0]  SEC_RESET    = 8'h00;
  localparam logic [7:0]  SEC_WMASK    = 8'hF9;
  // status layout follows the mask layout; overrun sits under the receive mask
  localparam int unsigned S_CONFLICT   = 0;
  localparam int unsigned S_OVERRUN    = 4;
  localparam int unsigned S_RXFULL     = 5;
  localparam int unsigned S_TEND       = 6;
  localparam int unsigned S_TEMPTY     = 7;
  localparam logic [7:0]  STAT_RESET   = 8'h00;
  localparam int unsigned M_FOUR_WIRE  = 0;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [7:0]  BYTE_IDLE    = 8'hFF;
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// ==== rtl/ssec_eng_if.sv ====
// control and event signals between the register block and the shift engine
`timescale 1ns/10ps
interface ssec_eng_if;
  logic       transmit_enable;
  logic       receive_enable;
  logic       tx_req;
  logic [7:0] tx_data;
  logic       take;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic       tx_end;
  logic       cs_rise;
  modport ctl (output transmit_enable, receive_enable, tx_req, tx_data,
               input  take, byte_done, rx_byte, tx_end, cs_rise);
  modport eng (input  transmit_enable, receive_enable, tx_req, tx_data,
               output take, byte_done, rx_byte, tx_end, cs_rise);
endinterface

// ==== rtl/ssec_engine.sv ====
// slave shift engine: mode 0, msb first, byte framed by chip select
`timescale 1ns/10ps
module ssec_engine
  import ssec_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic nrst,
  ssec_eng_if.eng   eif,
  input  wire logic serial_clk,
  input  wire logic serial_din,
  input  wire logic chip_select_pin,
  output logic      serial_dout_reg,
  output logic      serial_dout_oe_reg
);
  logic       sclk_prev_reg;
  logic       cs_prev_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_sh_reg;
  logic [7:0] tx_sh_reg;
  logic       loaded_reg;
  logic       tx_active_reg;
  logic       rise;
  logic       fall;
  logic       selected;

  // pins are synchronous to core_clk, so edges are taken directly
  assign rise     = serial_clk & ~sclk_prev_reg;
  assign fall     = ~serial_clk & sclk_prev_reg;
  assign selected = ~chip_select_pin;

  // pin history
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b1;
    end else begin
      sclk_prev_reg <= serial_clk;
      cs_prev_reg   <= chip_select_pin;
    end
  end

  // chip select rising edge, judged by the block as a conflict in four-wire mode
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      eif.cs_rise <= 1'b0;
    end else begin
      eif.cs_rise <= chip_select_pin & ~cs_prev_reg;
    end
  end

  // receive shifter and byte framing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_reg   <= 3'h0;
      rx_sh_reg     <= BYTE_ZERO;
      eif.byte_done <= 1'b0;
      eif.rx_byte   <= BYTE_ZERO;
    end else begin
      eif.byte_done <= 1'b0;
      if (!selected) begin
        bit_cnt_reg <= 3'h0;               // partial byte dropped on deselect
      end else if (rise) begin
        rx_sh_reg   <= {rx_sh_reg[6:0], serial_din};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == LAST_BIT) begin
          eif.byte_done <= 1'b1;
          eif.rx_byte   <= {rx_sh_reg[6:0], serial_din};
        end
      end
    end
  end

  // transmit shifter; first bit must sit on the pin before the first rise
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_sh_reg       <= BYTE_IDLE;
      serial_dout_reg <= 1'b1;
      loaded_reg      <= 1'b0;
      tx_active_reg   <= 1'b0;
      eif.take        <= 1'b0;
      eif.tx_end      <= 1'b0;
    end else begin
      eif.take   <= 1'b0;
      eif.tx_end <= 1'b0;
      if (!selected || (rise && bit_cnt_reg == LAST_BIT)) begin
        loaded_reg <= 1'b0;
        if (rise && selected && tx_active_reg && !eif.tx_req) begin
          eif.tx_end <= 1'b1;              // last byte out, nothing queued
        end
      end else if (!loaded_reg && bit_cnt_reg == 3'h0) begin
        loaded_reg <= 1'b1;
        if (eif.tx_req && eif.transmit_enable) begin
          eif.take        <= 1'b1;
          tx_active_reg   <= 1'b1;
          serial_dout_reg <= eif.tx_data[7];
          tx_sh_reg       <= {eif.tx_data[6:0], 1'b1};
        end else begin
          tx_active_reg   <= 1'b0;
          serial_dout_reg <= 1'b1;
          tx_sh_reg       <= BYTE_IDLE;
        end
      end else if (fall) begin
        serial_dout_reg <= tx_sh_reg[7];
        tx_sh_reg       <= {tx_sh_reg[6:0], 1'b1};
      end
    end
  end

  // data line driven only while selected
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      serial_dout_oe_reg <= 1'b0;
    end else begin
      serial_dout_oe_reg <= selected;
    end
  end
endmodule

// ==== testbench/ssec_ser_master.sv ====
// external serial master model: mode 0, msb first, framed by chip select
`timescale 1ns/10ps
module ssec_ser_master
  import ssec_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic serial_dout,
  output logic      serial_clk,
  output logic      serial_din,
  output logic      chip_select_pin
);
  // idle: deselected and clock parked low, it never runs between frames
  initial begin
    serial_clk      = 1'b0;
    serial_din      = 1'b0;
    chip_select_pin = 1'b1;
  end

  // one frame of nbits; half is core cycles per clock level, so speed can vary
  task automatic frame(input logic [7:0] tx, input int nbits, input int half,
                       output logic [7:0] rx);
    rx = BYTE_ZERO;
    chip_select_pin <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      serial_din <= tx[7-i];
      repeat (half) @(posedge core_clk);
      serial_clk <= 1'b1;
      rx = {rx[6:0], serial_dout}; // slave data taken on the rising edge
      repeat (half) @(posedge core_clk);
      serial_clk <= 1'b0;
    end
    repeat (half) @(posedge core_clk);
    chip_select_pin <= 1'b1;
    serial_din      <= ~serial_din; // released line must not keep a stale bit
  endtask
endmodule

// ==== testbench/ssec_tb_top.sv ====
// self-checking bench for the serial enable and interrupt control block
`timescale 1ns/10ps
module ssec_tb_top
  import ssec_pkg::*;
;
  localparam logic [AW-1:0] A_SEC  = {IDX_SEC, 2'b00};
  localparam logic [AW-1:0] A_STAT = {IDX_STATUS, 2'b00};
  localparam logic [AW-1:0] A_TXD  = {IDX_TXDATA, 2'b00};
  localparam logic [AW-1:0] A_RXD  = {IDX_RXDATA, 2'b00};
  localparam logic [AW-1:0] A_MODE = {IDX_MODE, 2'b00};
  localparam logic [AW-1:0] A_BAD  = 12'hFF0;

  logic          core_clk;
  logic          nrst;
  logic [AW-1:0] s_axi_awaddr;
  logic          s_axi_awvalid;
  logic          s_axi_awready;
  logic [31:0]   s_axi_wdata;
  logic [3:0]    s_axi_wstrb;
  logic          s_axi_wvalid;
  logic          s_axi_wready;
  logic [1:0]    s_axi_bresp;
  logic          s_axi_bvalid;
  logic          s_axi_bready;
  logic [AW-1:0] s_axi_araddr;
  logic          s_axi_arvalid;
  logic          s_axi_arready;
  logic [31:0]   s_axi_rdata;
  logic [1:0]    s_axi_rresp;
  logic          s_axi_rvalid;
  logic          s_axi_rready;
  logic          serial_clk;
  logic          serial_din;
  logic          chip_select_pin;
  logic          serial_dout;
  logic          serial_dout_oe;
  logic          irq;
  int            errors;
  int            num_checks;
  int            cycles;
  logic [31:0]   rd;
  logic [1:0]    rsp;
  logic [7:0]    srx;

  ssec_top u_ssec_top (
    .core_clk(core_clk), .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .serial_clk(serial_clk),
    .serial_din(serial_din), .chip_select_pin(chip_select_pin),
    .serial_dout(serial_dout), .serial_dout_oe(serial_dout_oe), .irq(irq)
  );

  ssec_ser_master u_ssec_ser_master (
    .core_clk(core_clk), .serial_dout(serial_dout), .serial_clk(serial_clk),
    .serial_din(serial_din), .chip_select_pin(chip_select_pin)
  );

  // 20 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t ns %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [AW-1:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
    axi_wr(a, d, rsp);
    chk(rsp, RESP_OKAY, "write resp");
  endtask

  task automatic rd_chk(input logic [AW-1:0] a, input logic [7:0] exp, input string what);
    axi_rd(a, rd, rsp);
    chk(rsp, RESP_OKAY, "read resp");
    chk(rd, exp, what);
  endtask

  // full frame; an edge passes first so chip select never flips twice in one step
  task automatic ser(input logic [7:0] tx, input int half, input logic [7:0] exp);
    @(posedge core_clk);
    u_ssec_ser_master.frame(tx, 8, half, srx);
    chk(srx, exp, "shifted out");
    wait_clk(2);
  endtask

  task automatic part_frame();
    @(posedge core_clk);
    fork
      u_ssec_ser_master.frame(8'hF0, 3, 2, srx);
      begin
        wait_clk(3);
        chk(serial_dout_oe, 1'b1, "data line driven");
      end
    join
    wait_clk(4);
    chk(serial_dout_oe, 1'b0, "data line released");
  endtask

  task automatic t_regs();
    rd_chk(A_SEC, SEC_RESET, "control reset");
    chk(irq, 1'b0, "irq after reset");
    wr(A_SEC, 8'hFF);
    rd_chk(A_SEC, 8'hF9, "control all ones");
    wr(A_SEC, 8'h06);
    rd_chk(A_SEC, 8'h00, "unassigned bits");
    s_axi_wstrb <= 4'hE;
    wr(A_SEC, 8'hFF);
    s_axi_wstrb <= 4'hF;
    rd_chk(A_SEC, 8'h00, "write without strobe");
    axi_wr(A_BAD, 8'h00, rsp);
    chk(rsp, RESP_SLVERR, "unmapped write");
    axi_rd(A_BAD, rd, rsp);
    chk(rsp, RESP_SLVERR, "unmapped read");
    chk(rd, 32'h00000000, "unmapped data");
    $display("test regs done");
  endtask

  task automatic t_rx();
    wr(A_SEC, 8'h08);
    ser(8'hA5, 2, BYTE_IDLE);
    chk(irq, 1'b0, "rx full masked");
    wr(A_SEC, 8'h28);
    wait_clk(3);
    chk(irq, 1'b1, "rx full unmasked");
    rd_chk(A_RXD, 8'hA5, "rx byte");
    rd_chk(A_STAT, 8'h20, "rx full flag");
    wait_clk(2);
    chk(irq, 1'b0, "irq cleared by read");
    ser(8'h5A, 5, BYTE_IDLE);
    ser(8'hC3, 2, BYTE_IDLE);
    chk(irq, 1'b1, "overrun irq");
    wr(A_SEC, 8'h08);
    wait_clk(3);
    chk(irq, 1'b0, "overrun masked");
    rd_chk(A_STAT, 8'h30, "overrun flag");
    rd_chk(A_RXD, 8'h5A, "first byte kept");
    wr(A_SEC, 8'h20);
    ser(8'h77, 2, BYTE_IDLE);
    rd_chk(A_STAT, 8'h00, "rx disabled");
    $display("test rx done");
  endtask

  task automatic t_tx();
    wr(A_SEC, 8'h00);
    wr(A_TXD, 8'h3C);
    rd_chk(A_TXD, 8'h01, "tx buffer full");
    ser(8'h00, 2, BYTE_IDLE);
    rd_chk(A_STAT, 8'h00, "no tx events");
    wr(A_SEC, 8'h10);
    ser(8'h00, 5, 8'h3C);
    rd_chk(A_TXD, 8'h00, "tx buffer taken");
    chk(irq, 1'b0, "tx irqs masked");
    wr(A_SEC, 8'h50);
    wait_clk(3);
    chk(irq, 1'b1, "tx end unmasked");
    wr(A_SEC, 8'h90);
    wait_clk(3);
    chk(irq, 1'b1, "tx empty unmasked");
    rd_chk(A_STAT, 8'hC0, "tx flags");
    wait_clk(2);
    chk(irq, 1'b0, "tx irq cleared");
    $display("test tx done");
  endtask

  // aborted frames: the chip select rise is the conflict cause
  task automatic t_conflict();
    wr(A_SEC, 8'h00);
    wr(A_MODE, 8'h00);
    part_frame();
    rd_chk(A_STAT, 8'h00, "no conflict three-wire");
    wr(A_MODE, 8'h01);
    rd_chk(A_MODE, 8'h01, "four-wire mode");
    part_frame();
    chk(irq, 1'b0, "conflict masked");
    wr(A_SEC, 8'h01);
    wait_clk(3);
    chk(irq, 1'b1, "conflict unmasked");
    rd_chk(A_STAT, 8'h01, "conflict flag");
    $display("test conflict done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog: whole run is a few hundred cycles, so this only trips on a hang
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("[FAIL] %0t ns timeout", $time);
      give_verdict();
    end
  end

  // reset, then the scenarios in turn
  initial begin
    errors        = 0;
    num_checks    = 0;
    cycles        = 0;
    nrst          = 1'b0;
    s_axi_awaddr  = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h00000000;
    s_axi_wstrb   = 4'hF;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs();
    t_rx();
    t_tx();
    t_conflict();
    give_verdict();
  end
endmodule
